// ==== bench/tb_tspc_top.sv ====
// Purpose: Self-checking bench for the touch sensor pin control block
// Assumes: 50 ns system clock, 6 ns link clock, host model on the serial pins
// Notes:   Expected judgments are computed here from values and threshold
`timescale 1ns/10ps
module tb_tspc_top;
    import tspc_pkg::*;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic external_reset_n = 1'b1;
    tspc_conv_t conv = '0;
    logic [7:0] thr = 8'h80;
    logic calib_error = 1'b0;
    logic system_error = 1'b0;
    logic gain_select = 1'b0;
    logic sa_sel = 1'b0;
    logic [2:0] measure_chan;
    logic [4:0] amp2_gain;
    logic [63:0] channel_values;
    logic [7:0] sense_inputs_oe;
    tspc_pass_t judgment_outputs;
    logic judgment_oe, error_out, error_oe, measure_done_irq;
    logic serial_clk, select_n, sda_si, sda_oe, so_out, so_oe;
    logic spi_mode, host_byte_valid, ack;
    logic [7:0] host_byte, rx, exp_j;
    logic sda_line, sa_line;
    int bad_count = 0;
    int checks_done = 0;
    int n;

    // Open-drain data with pull-up; SA pin turns around in SPI mode
    assign sda_line = sda_si & ~sda_oe;
    assign sa_line = so_oe ? so_out : sa_sel;

    initial forever #25 clk = ~clk;
    initial begin
        #1.3;
        forever #3 link_clk = ~link_clk;
    end

    tspc_top dut (.clk(clk), .rst_n(rst_n), .external_reset_n(external_reset_n),
        .conv(conv), .threshold(thr), .calib_error(calib_error),
        .system_error(system_error), .measure_chan(measure_chan), .amp2_gain(amp2_gain),
        .channel_values(channel_values), .sense_inputs_out(), .sense_inputs_oe(sense_inputs_oe),
        .ref_pin_oe(), .judgment_outputs(judgment_outputs), .judgment_oe(judgment_oe),
        .error_out(error_out), .error_oe(error_oe), .measure_done_irq(measure_done_irq),
        .gain_select(gain_select), .serial_clk(serial_clk), .select_n_mode_pin(select_n),
        .sda_si_in(sda_line), .sda_out(), .sda_oe(sda_oe), .addr_sel_or_serial_out_in(sa_line),
        .addr_sel_or_serial_out_out(so_out), .addr_sel_or_serial_out_oe(so_oe),
        .spi_mode(spi_mode), .host_byte(host_byte), .host_byte_valid(host_byte_valid));

    tspc_host host (.clk(clk), .link_clk(link_clk), .serial_clk(serial_clk),
        .select_n(select_n), .sda_si(sda_si), .sda_line(sda_line), .sa_line(sa_line));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One back-to-back pass of eight conversions
    task automatic run_pass(input logic [63:0] v);
        logic [7:0] m;
        logic [7:0] o;
        o = judgment_outputs.judge;
        for (int c = 0; c < 8; c++) begin
            m = ~(8'h01 << c);
            chk("chan", c, measure_chan);
            chk("sense_oe", m, sense_inputs_oe);
            exp_j[c] = v[c*8 +: 8] >= thr;
            conv = '{valid: 1'b1, value: v[c*8 +: 8]};
            tick(1);
            chk("irq", c == 7, measure_done_irq);
            chk("judge", c == 7 ? exp_j : o, judgment_outputs.judge);
        end
        conv.valid = 1'b0;
        chk("values", v, channel_values);
        chk("done", 1'b1, judgment_outputs.done);
        tick(1);
        chk("irq_end", 1'b0, measure_done_irq);
    endtask

    // External reset with a new gain strap
    task automatic ext_reset(input logic g);
        external_reset_n = 1'b0;
        gain_select = g;
        tick(4);
        chk("judge_oe", 1'b0, judgment_oe);
        chk("err_oe", 1'b0, error_oe);
        chk("sense_oe", 8'h00, sense_inputs_oe);
        external_reset_n = 1'b1;
        tick(10);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(10);
        chk("gain", TSPC_GAIN_LOW, amp2_gain);
        chk("spi", 1'b0, spi_mode);
        chk("err", 1'b0, error_out);
        chk("judge_oe", 1'b1, judgment_oe);
        host.i2c_addr({TSPC_ADDR_BASE, 1'b0}, ack);
        chk("ack_low", 1'b1, ack);
        host.i2c_addr(8'h2E, ack);
        chk("nack", 1'b0, ack);
        sa_sel = 1'b1;
        tick(4);
        host.i2c_addr(8'h2E, ack);
        chk("ack_high", 1'b1, ack);
        sa_sel = 1'b0;
        chk("spi", 1'b0, spi_mode);
        run_pass(64'h7EC0_10FF_0081_807F);
        thr = 8'hFF;
        run_pass(64'h7EC0_10FF_0081_807F);
        host.spi_bits(8'hA5, rx);
        chk("spi", 1'b1, spi_mode);
        n = 0;
        while (host_byte_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk("valid", 1'b1, host_byte_valid);
        chk("rx_byte", 8'hA5, host_byte);
        chk("so_byte", exp_j, rx);
        host.spi_end();
        tick(5);
        chk("spi_kept", 1'b1, spi_mode);
        calib_error = 1'b1;
        tick(1);
        calib_error = 1'b0;
        tick(3);
        chk("err", 1'b1, error_out);
        ext_reset(1'b1);
        chk("gain", TSPC_GAIN_HIGH, amp2_gain);
        chk("spi", 1'b0, spi_mode);
        chk("err", 1'b0, error_out);
        system_error = 1'b1;
        tick(1);
        system_error = 1'b0;
        tick(3);
        chk("err", 1'b1, error_out);
        end_sim();
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule

// ==== bench/tspc_host.sv ====
// Purpose: Host controller model on the shared serial pins
// Assumes: clk is the system clock, link_clk the 6 ns SPI clock source
// Notes:   I2C is paced on clk; the SPI clock runs only inside frames
`timescale 1ns/10ps
module tspc_host (
    // Clocks
    input wire logic clk,
    input wire logic link_clk,
    // Shared pins
    output logic serial_clk,
    output logic select_n,
    output logic sda_si,
    input wire logic sda_line,
    input wire logic sa_line
);
    // ----------------------------------------
    // Pin state, idle high while unused
    // ----------------------------------------
    logic use_spi = 1'b0;
    logic run = 1'b0;
    logic scl = 1'b1;
    logic sel = 1'b1;
    logic sda_drv = 1'b1;

    // Gated clock stands still outside frames
    assign serial_clk = use_spi ? (link_clk & run) : scl;
    assign select_n = sel;
    assign sda_si = sda_drv;

    task automatic pace(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Start, address byte, ack sample, stop
    task automatic i2c_addr(input logic [7:0] a, output logic ack);
        sda_drv = 1'b0;
        pace(6);
        scl = 1'b0;
        pace(3);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = a[i];
            pace(3);
            scl = 1'b1;
            pace(6);
            scl = 1'b0;
            pace(3);
        end
        sda_drv = 1'b1;
        pace(3);
        scl = 1'b1;
        pace(3);
        ack = ~sda_line;
        pace(3);
        scl = 1'b0;
        pace(6);
        sda_drv = 1'b0;
        pace(3);
        scl = 1'b1;
        pace(6);
        sda_drv = 1'b1;
        pace(6);
    endtask

    // Mode 0: data set on the falling edge, sampled on the rising
    task automatic spi_bits(input logic [7:0] tx, output logic [7:0] rx);
        use_spi = 1'b1;
        pace(2);
        sel = 1'b0;
        pace(4); // Mode flag must settle before the first edge
        for (int i = 7; i >= 0; i--) begin
            // Sample SO while settled, before the rising edge shifts it
            @(negedge link_clk);
            rx[i] = sa_line;
            sda_drv = tx[i];
            run = 1'b1;
            @(posedge link_clk);
        end
        @(negedge link_clk);
        run = 1'b0;
        sda_drv = ~sda_drv; // Released line must not keep the last bit
    endtask

    task automatic spi_end();
        sel = 1'b1;
        pace(2);
    endtask
endmodule

// ==== common/tspc_pkg.sv ====
// Purpose: Shared constants and carrier types for the touch sensor pin control block
// Assumes: 20 MHz system clock, eight sensing channels, 8-bit conversion results
// Notes:   Gain codes are multiples of the smallest second-amplifier setting
package tspc_pkg;

    // ------------------------------------------------------------
    // Sizes and codes
    // ------------------------------------------------------------
    localparam int unsigned TSPC_NCH = 8;
    localparam logic [2:0] TSPC_LAST_CH = 3'h7;
    localparam logic [4:0] TSPC_GAIN_LOW = 5'h07;
    localparam logic [4:0] TSPC_GAIN_HIGH = 5'h0E;
    localparam logic [6:0] TSPC_ADDR_BASE = 7'h16;
    localparam logic [3:0] TSPC_BYTE_BITS = 4'h8;
    localparam logic [1:0] TSPC_INIT_WAIT = 2'h3;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Result of one channel conversion from the analog front end
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } tspc_conv_t;

    // One open-drain or three-state pin as seen by the core
    typedef struct packed {
        logic out;
        logic oe;
    } tspc_pin_t;

    // Judgment set published at the end of a pass
    typedef struct packed {
        logic done;
        logic [TSPC_NCH-1:0] judge;
    } tspc_pass_t;

    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WRITE, I2C_READ, I2C_RACK
    } tspc_i2c_t;

endpackage

// ==== rtl/tspc_top.sv ====
// Purpose: Pin-level control of an eight-channel capacitive touch converter
// Assumes: Conversions arrive from the analog side on clk; SPI clock is the link clock
// Notes:   I2C is oversampled on clk; SPI shifts on the serial clock domain
`timescale 1ns/10ps
module tspc_top (
    // System
    input wire logic clk,
    input wire logic rst_n,
    input wire logic external_reset_n,
    // Analog front end
    input wire tspc_pkg::tspc_conv_t conv,
    input wire logic [7:0] threshold,
    input wire logic calib_error,
    input wire logic system_error,
    output logic [2:0] measure_chan,
    output logic [4:0] amp2_gain,
    output logic [63:0] channel_values,
    // Sensor pins
    output logic [7:0] sense_inputs_out,
    output logic [7:0] sense_inputs_oe,
    output logic ref_pin_oe,
    output tspc_pkg::tspc_pass_t judgment_outputs,
    output logic judgment_oe,
    output logic error_out,
    output logic error_oe,
    output logic measure_done_irq,
    input wire logic gain_select,
    // Serial interface
    input wire logic serial_clk,
    input wire logic select_n_mode_pin,
    input wire logic sda_si_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_sel_or_serial_out_in,
    output logic addr_sel_or_serial_out_out,
    output logic addr_sel_or_serial_out_oe,
    output logic spi_mode,
    output logic [7:0] host_byte,
    output logic host_byte_valid
);
    import tspc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address decode shared by the matcher and the checks
    function automatic logic [6:0] own_addr(input logic sel);
        own_addr = TSPC_ADDR_BASE | {6'h00, sel};
    endfunction

    function automatic logic [7:0] ch_onehot(input logic [2:0] ch);
        ch_onehot = 8'h01 << ch;
    endfunction

    // ------------------------------------------------------------
    // System clock state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] xrst_s;
        logic [1:0] sel_s;
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] sa_s;
        logic [1:0] gain_s;
        logic [1:0] tog_s;
        logic tog_prev;
        logic sel_prev;
        logic scl_prev;
        logic sda_prev;
        logic [1:0] init_cnt;
        logic [4:0] gain;
        logic spi;
        logic [2:0] chan;
        logic [7:0] acc;
        logic [7:0] judge;
        logic irq;
        logic err;
        logic [7:0][7:0] vals;
        tspc_i2c_t ist;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic rw;
        logic ack_on;
        logic sda_dr;
        logic [7:0] tx_src;
        logic [7:0] rx;
        logic rx_v;
    } tspc_sys_t;

    tspc_sys_t q;
    tspc_sys_t d;

    // Link domain state; counter and shifters reset by the frame's own chip select
    typedef struct packed {
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] rx;
        logic tog;
    } tspc_link_t;

    tspc_link_t lq;
    tspc_link_t ld;

    logic active;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic pass_end;
    logic judge_bit;
    logic link_rst_n;

    assign active = q.xrst_s[1] && (q.init_cnt == TSPC_INIT_WAIT);
    assign scl_rise = q.scl_s[1] && !q.scl_prev;
    assign scl_fall = !q.scl_s[1] && q.scl_prev;
    assign i2c_start = q.scl_s[1] && q.scl_prev && q.sda_prev && !q.sda_s[1];
    assign i2c_stop = q.scl_s[1] && q.scl_prev && !q.sda_prev && q.sda_s[1];
    assign judge_bit = conv.value >= threshold;
    assign pass_end = active && conv.valid && (q.chan == TSPC_LAST_CH);

    // ------------------------------------------------------------
    // Next state, system clock
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // Synchronisers; first stage read only by the second
        d.xrst_s = {q.xrst_s[0], external_reset_n};
        d.sel_s = {q.sel_s[0], select_n_mode_pin};
        d.scl_s = {q.scl_s[0], serial_clk};
        d.sda_s = {q.sda_s[0], sda_si_in};
        d.sa_s = {q.sa_s[0], addr_sel_or_serial_out_in};
        d.gain_s = {q.gain_s[0], gain_select};
        d.tog_s = {q.tog_s[0], lq.tog};
        d.tog_prev = q.tog_s[1];
        d.sel_prev = q.sel_s[1];
        d.scl_prev = q.scl_s[1];
        d.sda_prev = q.sda_s[1];
        d.irq = 1'b0;
        d.rx_v = 1'b0;
        if (!q.xrst_s[1]) begin
            // External reset holds the sequencer, judgment, error, mode and I2C slave at their initial state
            d.init_cnt = 2'h0;
            d.spi = 1'b0;
            d.chan = 3'h0;
            d.acc = 8'h00;
            d.judge = 8'h00;
            d.err = 1'b0;
            d.ist = I2C_IDLE;
            d.sda_dr = 1'b0;
            d.ack_on = 1'b0;
        end else if (q.init_cnt != TSPC_INIT_WAIT) begin
            // Wait for the pin synchronisers to fill, then catch the strap
            d.init_cnt = q.init_cnt + 2'h1;
            if (q.init_cnt == TSPC_INIT_WAIT - 2'h1) begin
                d.gain = q.gain_s[1] ? TSPC_GAIN_HIGH : TSPC_GAIN_LOW;
            end
            d.spi = 1'b0;
        end else begin
            // Sticky switch to SPI on the first falling chip select
            if (q.sel_prev && !q.sel_s[1]) begin
                d.spi = 1'b1;
            end
            // Measurement sequencer
            if (conv.valid) begin
                d.vals[q.chan] = conv.value;
                d.acc[q.chan] = judge_bit;
                d.chan = q.chan + 3'h1;
                if (q.chan == TSPC_LAST_CH) begin
                    d.judge = q.acc;
                    d.judge[TSPC_LAST_CH] = judge_bit;
                    d.irq = 1'b1;
                end
            end
            // Error is sticky until the next initialization
            if (calib_error || system_error) begin
                d.err = 1'b1;
            end
            // Judgment byte for SPI only changes between frames
            if (q.sel_s[1]) begin
                d.tx_src = q.judge;
            end
            // Byte handed over from the link domain
            if (q.tog_s[1] != q.tog_prev) begin
                d.rx = lq.rx;
                d.rx_v = q.spi;
            end
            // I2C slave, oversampled; ignored once in SPI mode
            if (q.spi) begin
                d.ist = I2C_IDLE;
                d.sda_dr = 1'b0;
            end else if (i2c_stop) begin
                d.ist = I2C_IDLE;
                d.sda_dr = 1'b0;
            end else if (i2c_start) begin
                d.ist = I2C_ADDR;
                d.bitcnt = 4'h0;
                d.sda_dr = 1'b0;
                d.ack_on = 1'b0;
            end else begin
                unique case (q.ist)
                    I2C_IDLE: begin
                        d.sda_dr = 1'b0;
                    end
                    I2C_ADDR, I2C_WRITE: begin
                        if (scl_rise) begin
                            d.sh = {q.sh[6:0], q.sda_s[1]};
                            d.bitcnt = q.bitcnt + 4'h1;
                            if (q.bitcnt == TSPC_BYTE_BITS - 4'h1) begin
                                d.ist = I2C_ACK;
                                d.ack_on = 1'b0;
                                if (q.ist == I2C_ADDR) begin
                                    d.rw = q.sda_s[1];
                                    if (q.sh[6:0] != own_addr(q.sa_s[1])) begin
                                        d.ist = I2C_IDLE;
                                    end
                                end else begin
                                    d.rx = {q.sh[6:0], q.sda_s[1]};
                                    d.rx_v = 1'b1;
                                end
                            end
                        end
                    end
                    I2C_ACK: begin
                        if (scl_fall && !q.ack_on) begin
                            d.ack_on = 1'b1;
                            d.sda_dr = 1'b1;
                        end else if (scl_fall) begin
                            d.bitcnt = 4'h0;
                            d.sda_dr = 1'b0;
                            d.ist = I2C_WRITE;
                            if (q.rw) begin
                                d.ist = I2C_READ;
                                d.sh = q.judge;
                                d.sda_dr = !q.judge[7];
                            end
                        end
                    end
                    I2C_READ: begin
                        if (scl_rise) begin
                            d.bitcnt = q.bitcnt + 4'h1;
                        end else if (scl_fall) begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_dr = !q.sh[6];
                            if (q.bitcnt == TSPC_BYTE_BITS) begin
                                d.sda_dr = 1'b0;
                                d.ist = I2C_RACK;
                            end
                        end
                    end
                    I2C_RACK: begin
                        if (scl_rise) begin
                            d.ist = I2C_IDLE;
                        end
                    end
                    default: begin
                        d.ist = I2C_IDLE;
                    end
                endcase
            end
        end
    end

    // Synchroniser stages for the high-idle serial pins (select, clock, data) come out of reset high; the external reset stages come out low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sel_s <= 2'h3;
            q.sel_prev <= 1'b1;
            q.scl_s <= 2'h3;
            q.scl_prev <= 1'b1;
            q.sda_s <= 2'h3;
            q.sda_prev <= 1'b1;
            q.gain <= TSPC_GAIN_LOW;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Link domain: SPI mode 0 shifter on the serial clock
    // ------------------------------------------------------------
    // Frame select doubles as reset; the clock may stop between frames
    assign link_rst_n = rst_n && !select_n_mode_pin;

    always_comb begin
        ld = lq;
        ld.sh = {lq.sh[6:0], sda_si_in};
        ld.bitcnt = lq.bitcnt + 3'h1;
        ld.tx = (lq.bitcnt == 3'h0) ? {q.tx_src[6:0], 1'b0} : {lq.tx[6:0], 1'b0};
        if (lq.bitcnt == TSPC_LAST_CH) begin
            ld.rx = {lq.sh[6:0], sda_si_in};
            ld.tog = !lq.tog;
        end
    end

    // Toggle survives frame resets so every byte is seen exactly once
    always_ff @(posedge serial_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lq.bitcnt <= 3'h0;
            lq.sh <= 8'h00;
            lq.tx <= 8'h00;
            // Toggle cleared by power-on reset only, never by a frame end
            if (!rst_n) begin
                lq.tog <= 1'b0;
            end
        end else begin
            lq <= ld;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // While active, only the channel under measurement floats; others pulled low
    assign sense_inputs_out = 8'h00;
    assign sense_inputs_oe = active ? ~ch_onehot(q.chan) : 8'h00;
    assign ref_pin_oe = 1'b0;
    assign judgment_outputs.done = q.irq;
    assign judgment_outputs.judge = q.judge;
    assign judgment_oe = q.xrst_s[1];
    assign error_out = q.err;
    assign error_oe = q.xrst_s[1];
    assign measure_done_irq = q.irq;
    assign measure_chan = q.chan;
    assign amp2_gain = q.gain;
    assign channel_values = q.vals;
    assign spi_mode = q.spi;
    assign host_byte = q.rx;
    assign host_byte_valid = q.rx_v;
    // Open-drain data: drive low only
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_dr && !q.spi;
    // Serial out mirrors the first bit before the first clock edge
    assign addr_sel_or_serial_out_out = (lq.bitcnt == 3'h0) ? q.tx_src[7] : lq.tx[7];
    assign addr_sel_or_serial_out_oe = q.spi && !select_n_mode_pin;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_others_low: assert property (active |-> $countones(sense_inputs_oe) == 7
        && !sense_inputs_oe[q.chan]) else $error("measured channel not floating");
    a_value_stored: assert property (active && conv.valid
        |=> q.vals[$past(q.chan)] == $past(conv.value)) else $error("value lost");
    a_pass_publish: assert property (pass_end |=> measure_done_irq
        && judgment_outputs.judge[7] == $past(judge_bit)) else $error("pass not published");
    a_judge_steady: assert property (!measure_done_irq && q.xrst_s[1]
        |-> $stable(q.judge)) else $error("judgment moved mid pass");
    a_error_sticky: assert property (active && (calib_error || system_error)
        ##1 q.xrst_s[1] |-> error_out) else $error("error flag not raised");
    a_gain_strap: assert property (q.xrst_s[1] && q.init_cnt == 2'h2
        |=> amp2_gain == ($past(q.gain_s[1]) ? 5'h0E : 5'h07)) else $error("bad gain");
    a_i2c_after_init: assert property (q.init_cnt != TSPC_INIT_WAIT |=> !spi_mode)
        else $error("spi before init done");
    a_spi_entry: assert property (active && q.sel_prev && !q.sel_s[1]
        ##1 q.xrst_s[1] |-> spi_mode [*2]) else $error("spi mode not kept");
    a_sda_quiet_spi: assert property (spi_mode |-> !sda_oe)
        else $error("data pin driven in spi");
    a_hiz_reset: assert property (!q.xrst_s[1] |-> !judgment_oe && !error_oe
        && sense_inputs_oe == 8'h00) else $error("pins driven in reset");
    a_addr_ack: assert property (q.ist == I2C_ADDR && scl_rise && q.bitcnt == 4'h7
        && !i2c_stop && !i2c_start && !spi_mode && q.sh[6:0] == own_addr(q.sa_s[1])
        |=> q.ist == I2C_ACK) else $error("own address not acknowledged");
    a_link_count: assert property (@(posedge serial_clk) disable iff (!link_rst_n)
        lq.bitcnt == 3'h7 |=> lq.bitcnt == 3'h0 && lq.tog != $past(lq.tog))
        else $error("byte boundary missed");

endmodule
